// file: verilog/annp_regs.sv
// PHY-side auto-negotiation expansion, next-page and gigabit config registers
//
// What this block does
// - Location-valid bit reads one after reset
// - Store-place bit reads one: pages land register 8
// - Parallel-detect fault latches high, clears on read
// - Page-received latches high, clears on status read
// - Partner next-page and autoneg ability shown read-only
// - Local next-page capability always reads one
// - Management sets more-pages flag while pages follow
// - Message flag, reset one, selects message page
// - Writable ack-two flag, reset zero, goes out
// - Transmit toggle flips per page, reads inverted at first; its bit on tx_next_page starts at zero
// - Eleven-bit writable page content, reset one
// - Received next page captured, reset 2001h
// - Received toggle flips per page, starts inverted
// - Three-bit test mode, zero is normal
// - Manual role enable forces master or slave
// - Port-type bit: zero single, one multi-port
// - Gigabit duplex advertise bits, reset one, then loaded from straps
// - Auto TDR launches after each link drop
`timescale 1ns/1ps
module annp_regs
  import annp_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Management channel
  annp_mgmt_if.phy        mgmt,
  // Auto-negotiation engine status
  input  wire logic       pd_fault_evt,
  input  wire logic       page_rx_evt,
  input  wire logic [15:0] page_rx_word,
  input  wire logic       page_tx_evt,
  input  wire logic       partner_np_capable,
  input  wire logic       partner_an_capable,
  input  wire logic       base_adv_toggle_src,
  input  wire logic       partner_base_toggle_src,
  input  wire logic       link_down_evt,
  // Strap levels for duplex advertisement
  input  wire logic       strap_adv_fd,
  input  wire logic       strap_adv_hd,
  // Configuration towards the PHY core
  output logic [15:0]     tx_next_page,
  output logic [2:0]      test_mode,
  output logic            force_role_enable,
  output logic            force_role_value,
  output logic            multi_port,
  output logic            adv_gig_full_duplex,
  output logic            adv_gig_half_duplex,
  output logic            tdr_start
);

  logic        ack_q;
  logic [15:0] rdata_q;
  logic        pd_fault_q;
  logic        page_rx_q;
  logic        partner_np_q;
  logic        partner_an_q;
  logic [15:0] np_tx_q;
  logic        tx_toggle_q;
  logic        tx_started_q;
  logic [15:0] np_rx_q;
  logic        rx_toggle_q;
  logic        rx_started_q;
  logic [15:0] cfg_q;
  logic        strap_taken_q;
  logic        tdr_start_q;

  // Access decode
  wire         access     = mgmt.req && !ack_q;
  wire         wr_access  = access && mgmt.we;
  wire         rd_access  = access && !mgmt.we;
  wire         hit_exp    = (mgmt.addr == ANNP_OFF_EXP_STATUS);
  wire         hit_np_tx  = (mgmt.addr == ANNP_OFF_NP_TX);
  wire         hit_np_rx  = (mgmt.addr == ANNP_OFF_NP_RX);
  wire         hit_cfg    = (mgmt.addr == ANNP_OFF_GIG_CFG);
  wire         exp_clear  = rd_access && hit_exp;

  // Live views of the read words
  wire         tx_toggle_now = tx_started_q ? tx_toggle_q : !base_adv_toggle_src;
  wire         rx_toggle_now = rx_started_q ? rx_toggle_q : !partner_base_toggle_src;
  wire [15:0]  exp_word;
  assign exp_word[15:7]              = 9'h000;
  assign exp_word[ANNP_EXP_LOC_VALID] = 1'b1;
  assign exp_word[ANNP_EXP_STORE]     = 1'b1;
  assign exp_word[ANNP_EXP_PD_FAULT]  = pd_fault_q;
  assign exp_word[ANNP_EXP_LP_NP]     = partner_np_q;
  assign exp_word[ANNP_EXP_LOCAL_NP]  = 1'b1;
  assign exp_word[ANNP_EXP_PAGE_RX]   = page_rx_q;
  assign exp_word[ANNP_EXP_LP_AN]     = partner_an_q;
  wire [15:0]  np_tx_word = {np_tx_q[15:12], tx_toggle_now, np_tx_q[10:0]} & ANNP_WMASK_NP_TX
                            | {4'h0, tx_toggle_now, 11'h000};
  wire [15:0]  np_rx_word = {np_rx_q[15:12], rx_toggle_now, np_rx_q[10:0]};
  wire [15:0]  read_mux   = hit_exp   ? exp_word   :
                            hit_np_tx ? np_tx_word :
                            hit_np_rx ? np_rx_word :
                            hit_cfg   ? cfg_q      : 16'h0000;

  // Next values of the mixed registers
  wire [15:0]  np_tx_wr  = mgmt.wdata & ANNP_WMASK_NP_TX;
  wire [15:0]  cfg_wr    = mgmt.wdata & ANNP_WMASK_GIG_CFG;

  // Channel answer: one cycle after the request is seen
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      ack_q <= access;
      if (rd_access) begin
        rdata_q <= read_mux; // Value sampled before the clear lands
      end
    end
  end

  // Latched-high events, the set wins over the read clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pd_fault_q <= ANNP_RST_EXP_STATUS[ANNP_EXP_PD_FAULT];
      page_rx_q  <= ANNP_RST_EXP_STATUS[ANNP_EXP_PAGE_RX];
    end else begin
      pd_fault_q <= pd_fault_evt || (pd_fault_q && !exp_clear);
      page_rx_q  <= page_rx_evt || (page_rx_q && !exp_clear);
    end
  end

  // Partner ability levels
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      partner_np_q <= ANNP_RST_EXP_STATUS[ANNP_EXP_LP_NP];
      partner_an_q <= ANNP_RST_EXP_STATUS[ANNP_EXP_LP_AN];
    end else begin
      partner_np_q <= partner_np_capable;
      partner_an_q <= partner_an_capable;
    end
  end

  // Transmit next page and its toggle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      np_tx_q      <= ANNP_RST_NP_TX;
      tx_toggle_q  <= ANNP_RST_NP_TX[ANNP_NP_TOGGLE];
      tx_started_q <= 1'b0;
    end else begin
      if (wr_access && hit_np_tx) begin
        np_tx_q <= np_tx_wr;
      end
      if (page_tx_evt) begin
        tx_toggle_q  <= !tx_toggle_now;
        tx_started_q <= 1'b1;
      end
    end
  end

  // Captured partner next page and its toggle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      np_rx_q      <= ANNP_RST_NP_RX;
      rx_toggle_q  <= ANNP_RST_NP_RX[ANNP_NP_TOGGLE];
      rx_started_q <= 1'b0;
    end else if (page_rx_evt) begin
      np_rx_q      <= page_rx_word;
      rx_toggle_q  <= !rx_toggle_now;
      rx_started_q <= 1'b1;
    end
  end

  // Gigabit config; straps load once after reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q         <= ANNP_RST_GIG_CFG;
      strap_taken_q <= 1'b0;
    end else begin
      strap_taken_q <= 1'b1;
      if (wr_access && hit_cfg) begin
        cfg_q <= cfg_wr;
      end else if (!strap_taken_q) begin
        cfg_q[ANNP_CFG_ADV_FD] <= strap_adv_fd;
        cfg_q[ANNP_CFG_ADV_HD] <= strap_adv_hd;
      end
    end
  end

  // Automatic cable test after each link drop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tdr_start_q <= 1'b0;
    end else begin
      tdr_start_q <= link_down_evt && cfg_q[ANNP_CFG_AUTO_TDR];
    end
  end

  // Outputs
  assign mgmt.ack            = ack_q;
  assign mgmt.rdata          = rdata_q;
  assign tx_next_page        = {np_tx_q[15:12], tx_toggle_q, np_tx_q[10:0]};
  assign test_mode           = cfg_q[15:ANNP_CFG_TEST_LO];
  assign force_role_enable   = cfg_q[ANNP_CFG_ROLE_EN];
  assign force_role_value    = cfg_q[ANNP_CFG_ROLE_VAL];
  assign multi_port          = cfg_q[ANNP_CFG_MULTIPORT];
  assign adv_gig_full_duplex = cfg_q[ANNP_CFG_ADV_FD];
  assign adv_gig_half_duplex = cfg_q[ANNP_CFG_ADV_HD];
  assign tdr_start           = tdr_start_q;

endmodule

// file: verilog/annp_pkg.sv
// Shared constants for the auto-negotiation next-page register bank
package annp_pkg;
  // Management register offsets
  localparam logic [4:0] ANNP_OFF_BASE_ADV   = 5'h04;
  localparam logic [4:0] ANNP_OFF_PARTNER    = 5'h05;
  localparam logic [4:0] ANNP_OFF_EXP_STATUS = 5'h06;
  localparam logic [4:0] ANNP_OFF_NP_TX      = 5'h07;
  localparam logic [4:0] ANNP_OFF_NP_RX      = 5'h08;
  localparam logic [4:0] ANNP_OFF_GIG_CFG    = 5'h09;
  // Reset values
  localparam logic [15:0] ANNP_RST_EXP_STATUS = 16'h0064;
  localparam logic [15:0] ANNP_RST_NP_TX      = 16'h2001;
  localparam logic [15:0] ANNP_RST_NP_RX      = 16'h2001;
  localparam logic [15:0] ANNP_RST_GIG_CFG    = 16'h0300;
  // Expansion status bit positions
  localparam int ANNP_EXP_LOC_VALID = 6;
  localparam int ANNP_EXP_STORE     = 5;
  localparam int ANNP_EXP_PD_FAULT  = 4;
  localparam int ANNP_EXP_LP_NP     = 3;
  localparam int ANNP_EXP_LOCAL_NP  = 2;
  localparam int ANNP_EXP_PAGE_RX   = 1;
  localparam int ANNP_EXP_LP_AN     = 0;
  // Next-page word bit positions
  localparam int ANNP_NP_MORE    = 15;
  localparam int ANNP_NP_ACK     = 14;
  localparam int ANNP_NP_MSG     = 13;
  localparam int ANNP_NP_ACK2    = 12;
  localparam int ANNP_NP_TOGGLE  = 11;
  localparam int ANNP_NP_CODE_HI = 10;
  // Gigabit configuration bit positions
  localparam int ANNP_CFG_TEST_LO   = 13;
  localparam int ANNP_CFG_ROLE_EN   = 12;
  localparam int ANNP_CFG_ROLE_VAL  = 11;
  localparam int ANNP_CFG_MULTIPORT = 10;
  localparam int ANNP_CFG_ADV_FD    = 9;
  localparam int ANNP_CFG_ADV_HD    = 8;
  localparam int ANNP_CFG_AUTO_TDR  = 7;
  // Writable masks of the two mixed registers
  localparam logic [15:0] ANNP_WMASK_NP_TX   = 16'hb7ff;
  localparam logic [15:0] ANNP_WMASK_GIG_CFG = 16'hff80;
  // Test transmission selections
  typedef enum logic [2:0] {
    ANNP_TM_NORMAL    = 3'b000,
    ANNP_TM_WAVEFORM  = 3'b001,
    ANNP_TM_JIT_MST   = 3'b010,
    ANNP_TM_JIT_SLV   = 3'b011,
    ANNP_TM_DISTORT   = 3'b100,
    ANNP_TM_SCR_IDLE  = 3'b101,
    ANNP_TM_REP_0001  = 3'b110,
    ANNP_TM_PULSE_63Z = 3'b111
  } annp_test_mode_t;
  // Controller bus offsets (byte addresses)
  localparam logic [3:0] ANNP_BUS_CMD    = 4'h0;
  localparam logic [3:0] ANNP_BUS_STATUS = 4'h4;
  // Command word fields
  localparam int ANNP_CMD_ADDR_LO  = 16;
  localparam int ANNP_CMD_WRITE    = 24;
endpackage

// file: verilog/annp_mgmt_if.sv
// Management register access channel between controller and PHY bank
`timescale 1ns/1ps
interface annp_mgmt_if;
  logic        req;
  logic        we;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic        ack;
  logic [15:0] rdata;
  // Station management controller end
  modport ctrl (output req, output we, output addr, output wdata, input ack, input rdata);
  // PHY register bank end
  modport phy (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface

// file: verilog/annp_host.sv
// Station management controller: Avalon-MM command registers to PHY bank
`timescale 1ns/1ps
module annp_host
  import annp_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Management channel
  annp_mgmt_if.ctrl        mgmt
);

  typedef enum logic [0:0] {
    ANNP_H_IDLE = 1'b0,
    ANNP_H_BUSY = 1'b1
  } annp_host_state_t;

  annp_host_state_t state_q;
  logic             wait_q;
  logic [31:0]      rdata_q;
  logic             req_q;
  logic             we_q;
  logic [4:0]       addr_q;
  logic [15:0]      wdata_q;
  logic [15:0]      last_rd_q;

  // Bus decode
  wire         bus_go    = (avs_read || avs_write) && wait_q;
  wire         hit_cmd   = (avs_address == ANNP_BUS_CMD);
  wire         hit_stat  = (avs_address == ANNP_BUS_STATUS);
  // A command takes effect only at the edge that sees waitrequest low
  wire         bus_take  = (avs_read || avs_write) && !wait_q;
  wire         launch    = bus_take && avs_write && hit_cmd && (state_q == ANNP_H_IDLE);
  wire [31:0]  stat_word = {last_rd_q, 15'h0000, (state_q == ANNP_H_BUSY)};
  wire [31:0]  bus_rd    = hit_stat ? stat_word : 32'h0000_0000;

  // Bus answer: waitrequest drops for the single accepting edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= !bus_go;
      if (bus_go && avs_read) begin
        rdata_q <= bus_rd;
      end
    end
  end

  // Management access sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ANNP_H_IDLE;
      req_q     <= 1'b0;
      we_q      <= 1'b0;
      addr_q    <= 5'h00;
      wdata_q   <= 16'h0000;
      last_rd_q <= 16'h0000;
    end else begin
      case (state_q)
        ANNP_H_IDLE: begin
          if (launch) begin
            state_q <= ANNP_H_BUSY;
            req_q   <= 1'b1;
            we_q    <= avs_writedata[ANNP_CMD_WRITE];
            addr_q  <= avs_writedata[ANNP_CMD_ADDR_LO +: 5];
            wdata_q <= avs_writedata[15:0];
          end
        end
        ANNP_H_BUSY: begin
          if (mgmt.ack) begin
            state_q <= ANNP_H_IDLE;
            req_q   <= 1'b0;
            if (!we_q) begin
              last_rd_q <= mgmt.rdata;
            end
          end
        end
        default: begin
          state_q <= ANNP_H_IDLE;
          req_q   <= 1'b0;
        end
      endcase
    end
  end

  // Outputs
  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;
  assign mgmt.req        = req_q;
  assign mgmt.we         = we_q;
  assign mgmt.addr       = addr_q;
  assign mgmt.wdata      = wdata_q;

endmodule

// file: testbench/annp_properties.sv
// Checker on the management channel between host and register bank
`timescale 1ns/1ps
module annp_properties (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Management channel
  input wire logic        req,
  input wire logic        we,
  input wire logic [4:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        ack,
  input wire logic [15:0] rdata
);
  // Answer to a read
  wire rd = ack && !we;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Handshake on the channel
  a_ack_next: assert property (req && !ack |=> ack)
    else $error("ack not one cycle after request");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (ack |-> req)
    else $error("ack without request");
  a_req_hold: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
    else $error("request changed before ack");
  a_req_drop: assert property (ack |=> !req)
    else $error("request kept after ack");
  // Fixed and reserved bits seen on reads
  a_status_fixed: assert property (rd && addr == 5'h06 |-> rdata[6:5] == 2'h3 && rdata[2])
    else $error("status fixed bits wrong");
  a_status_rsvd: assert property (rd && addr == 5'h06 |-> rdata[15:7] == 9'h0)
    else $error("status reserved bits set");
  a_cfg_rsvd: assert property (rd && addr == 5'h09 |-> rdata[6:0] == 7'h0)
    else $error("config reserved bits set");
  a_tx_rsvd: assert property (rd && addr == 5'h07 |-> !rdata[14])
    else $error("next page reserved bit set");
  // Main scenarios
  c_status_rd: cover property (rd && addr == 5'h06 && rdata[4]);
  c_cfg_wr: cover property (ack && we && addr == 5'h09);
  c_np_rd: cover property (rd && addr == 5'h08);
endmodule

// file: testbench/annp_regs_tb.sv
// Testbench joining host and register bank over the management channel
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
  $display("Error %s exp %h got %h", nm, e, s); end end
module annp_regs_tb
  import annp_pkg::*;
;
  logic        mclk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic        pd_fault_evt, page_rx_evt, page_tx_evt, link_down_evt, tdr_start;
  logic        partner_np_capable, partner_an_capable, base_adv_toggle_src, partner_base_toggle_src;
  logic        strap_adv_fd, strap_adv_hd, force_role_enable, force_role_value, multi_port;
  logic        adv_gig_full_duplex, adv_gig_half_duplex;
  logic [15:0] page_rx_word, tx_next_page;
  logic [2:0]  test_mode;
  wire [4:0]   cfg_bits = {force_role_enable, force_role_value, multi_port,
                           adv_gig_full_duplex, adv_gig_half_duplex};
  int          error_cnt = 0;
  int          compares = 0;
  // The two ends and the checker
  annp_mgmt_if annp_mgmt_if_inst ();
  annp_host annp_host_inst (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mgmt(annp_mgmt_if_inst));
  annp_regs annp_regs_inst (.mclk(mclk), .rst_n(rst_n), .mgmt(annp_mgmt_if_inst),
    .pd_fault_evt(pd_fault_evt), .page_rx_evt(page_rx_evt), .page_rx_word(page_rx_word),
    .page_tx_evt(page_tx_evt), .partner_np_capable(partner_np_capable),
    .partner_an_capable(partner_an_capable), .base_adv_toggle_src(base_adv_toggle_src),
    .partner_base_toggle_src(partner_base_toggle_src), .link_down_evt(link_down_evt),
    .strap_adv_fd(strap_adv_fd), .strap_adv_hd(strap_adv_hd), .tx_next_page(tx_next_page),
    .test_mode(test_mode), .force_role_enable(force_role_enable), .force_role_value(force_role_value),
    .multi_port(multi_port), .adv_gig_full_duplex(adv_gig_full_duplex),
    .adv_gig_half_duplex(adv_gig_half_duplex), .tdr_start(tdr_start));
  annp_properties annp_properties_inst (.mclk(mclk), .rst_n(rst_n), .req(annp_mgmt_if_inst.req),
    .we(annp_mgmt_if_inst.we), .addr(annp_mgmt_if_inst.addr), .wdata(annp_mgmt_if_inst.wdata),
    .ack(annp_mgmt_if_inst.ack), .rdata(annp_mgmt_if_inst.rdata));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    `CHK("waitrequest", 1'b0, avs_waitrequest)
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  // Register bank access by command word, polled until idle or 20 polls
  task automatic phy(input logic w, input logic [4:0] off, input logic [15:0] d, output logic [15:0] q);
    logic [31:0] s;
    int n;
    n = 0;
    bus(ANNP_BUS_CMD, 1'b1, {7'h0, w, 3'h0, off, d}, s);
    do begin
      bus(ANNP_BUS_STATUS, 1'b0, 32'h0, s);
      n++;
    end while (s[0] !== 1'b0 && n < 20);
    q = s[31:16];
  endtask
  task automatic wr(input logic [4:0] off, input logic [15:0] d);
    logic [15:0] q;
    phy(1'b1, off, d, q);
  endtask
  task automatic rchk(input logic [4:0] off, input logic [15:0] e);
    logic [15:0] q;
    phy(1'b0, off, 16'h0, q);
    `CHK("phy read", e, q)
  endtask
  // One-cycle pulse on the chosen event inputs (fault, page rx, page tx, link down)
  task automatic pulse(input logic [3:0] m);
    {pd_fault_evt, page_rx_evt, page_tx_evt, link_down_evt} <= m;
    @(posedge mclk);
    {pd_fault_evt, page_rx_evt, page_tx_evt, link_down_evt} <= 4'h0;
    @(posedge mclk);
  endtask
  // Link drop, then count cable test launches
  task automatic tdr(input logic [3:0] e);
    logic [3:0] n;
    n = 4'h0;
    link_down_evt <= 1'b1;
    @(posedge mclk);
    link_down_evt <= 1'b0;
    repeat (5) begin
      @(posedge mclk);
      n += {3'h0, tdr_start};
    end
    `CHK("tdr_start", e, n)
  endtask
  task automatic t_reset();
    rchk(ANNP_OFF_EXP_STATUS, ANNP_RST_EXP_STATUS);
    rchk(ANNP_OFF_NP_TX, ANNP_RST_NP_TX);
    rchk(ANNP_OFF_NP_RX, ANNP_RST_NP_RX);
    rchk(ANNP_OFF_GIG_CFG, 16'h0200);
    `CHK("adv", 2'h2, {adv_gig_full_duplex, adv_gig_half_duplex})
    base_adv_toggle_src <= 1'b0;
    partner_base_toggle_src <= 1'b0;
    rchk(ANNP_OFF_NP_TX, 16'h2801);
    rchk(ANNP_OFF_NP_RX, 16'h2801);
    base_adv_toggle_src <= 1'b1;
    partner_base_toggle_src <= 1'b1;
  endtask
  task automatic t_events();
    partner_np_capable <= 1'b1;
    partner_an_capable <= 1'b1;
    page_rx_word <= 16'hdaa5;
    pulse(4'hc);
    rchk(ANNP_OFF_EXP_STATUS, 16'h007f);
    rchk(ANNP_OFF_EXP_STATUS, 16'h006d);
    rchk(ANNP_OFF_NP_RX, 16'hdaa5);
    page_rx_word <= 16'h5801;
    pulse(4'h4);
    rchk(ANNP_OFF_NP_RX, 16'h5001);
    rchk(ANNP_OFF_EXP_STATUS, 16'h006f);
  endtask
  task automatic t_tx();
    wr(ANNP_OFF_NP_TX, 16'hffff);
    rchk(ANNP_OFF_NP_TX, 16'hb7ff);
    pulse(4'h2);
    rchk(ANNP_OFF_NP_TX, 16'hbfff);
    `CHK("tx_next_page", 16'hbfff, tx_next_page)
    wr(ANNP_OFF_NP_TX, 16'h0000);
    rchk(ANNP_OFF_NP_TX, 16'h0800);
  endtask
  task automatic t_config();
    for (int i = 0; i < 8; i++) begin
      wr(ANNP_OFF_GIG_CFG, {i[2:0], 13'h0});
      rchk(ANNP_OFF_GIG_CFG, {i[2:0], 13'h0});
      `CHK("test_mode", i[2:0], test_mode)
    end
    wr(ANNP_OFF_GIG_CFG, 16'h1fff);
    rchk(ANNP_OFF_GIG_CFG, 16'h1f80);
    `CHK("cfg", 5'h1f, cfg_bits)
    tdr(4'h1);
    wr(ANNP_OFF_GIG_CFG, 16'h1000);
    `CHK("cfg", 5'h10, cfg_bits)
    tdr(4'h0);
  endtask
  task automatic t_refused();
    logic [31:0] s;
    bus(4'h8, 1'b0, 32'h0, s);
    `CHK("unmapped", 32'h0, s)
    wr(ANNP_OFF_NP_RX, 16'hffff);
    rchk(ANNP_OFF_NP_RX, 16'h5001);
    wr(ANNP_OFF_EXP_STATUS, 16'hffff);
    rchk(ANNP_OFF_EXP_STATUS, 16'h006d);
    wr(5'h0d, 16'h001f);
    rchk(5'h0d, 16'h0000);
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #60000;
    error_cnt++;
    results();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {pd_fault_evt, page_rx_evt, page_tx_evt, link_down_evt, page_rx_word} = '0;
    {partner_np_capable, partner_an_capable} = 2'h0;
    {base_adv_toggle_src, partner_base_toggle_src, strap_adv_fd, strap_adv_hd} = 4'he;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_events();
    t_tx();
    t_config();
    t_refused();
    results();
  end
endmodule
